/* hw/pfh_defs.svh */
// Constants for the parallel flash host controller
`ifndef PFH_DEFS_SVH
`define PFH_DEFS_SVH
`define PFH_ADDR_W        18
`define PFH_DATA_W        8
`define PFH_CLK_PERIOD_NS 25
// Phase lengths in ns; counts round up to whole cycles
`define PFH_SETUP_NS      50
`define PFH_STROBE_NS     100
`define PFH_HOLD_NS       50
`define PFH_RESET_NS      500
`define PFH_CNT_OF(ns)    (((ns) + `PFH_CLK_PERIOD_NS - 1) / `PFH_CLK_PERIOD_NS)
`define PFH_CNT_W         8
// Command encodings and unlock addresses
`define PFH_UNLOCK_A1     18'h05555
`define PFH_UNLOCK_A2     18'h02AAA
`define PFH_UNLOCK_D1     8'hAA
`define PFH_UNLOCK_D2     8'h55
`define PFH_CMD_ID        8'h90
`define PFH_CMD_READ      8'hF0
`define PFH_ID_MAKER_ADDR 18'h00000
`define PFH_ID_PART_ADDR  18'h00001
`endif

/* hw/pfh_host.sv */
// Host-side bus sequencer driving a byte-wide parallel flash
`timescale 1ns/1ps
`include "pfh_defs.svh"
// How it works
// - Sample data only while chip select and output gate are both low.
// - Writes drop write strobe with chip select low and output gate high.
// - Host holds page bit low during identifier reads.
// - Host reports a reset so the caller can reissue interrupted work.
module pfh_host
	import pfh_pkg::*;
#(
	parameter int SETUP_CYC  = `PFH_CNT_OF(`PFH_SETUP_NS),
	parameter int STROBE_CYC = `PFH_CNT_OF(`PFH_STROBE_NS),
	parameter int HOLD_CYC   = `PFH_CNT_OF(`PFH_HOLD_NS),
	parameter int RESET_CYC  = `PFH_CNT_OF(`PFH_RESET_NS)
) (
	// Clock and reset
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rst,
	// Request
	input  wire logic                   i_req,
	input  wire pfh_op_type             i_op,
	input  wire logic [`PFH_ADDR_W-1:0] i_addr,
	input  wire logic [`PFH_DATA_W-1:0] i_wdata,
	input  wire logic                   i_supply_low,
	// Answer
	output logic                        o_busy,
	output logic                        o_done,
	output logic [`PFH_DATA_W-1:0]      o_rdata,
	output logic                        o_parity_err,
	output logic                        o_reset_done,
	// Flash pins
	output logic                        o_chip_select_n,
	output logic                        o_output_gate_n,
	output logic                        o_write_strobe_n,
	output logic                        o_hard_init_n,
	output logic                        o_id_override_pin,
	output logic [`PFH_ADDR_W-1:0]      o_address_lines,
	output logic [`PFH_DATA_W-1:0]      o_data_lines,
	output logic                        o_data_lines_oe,
	input  wire logic [`PFH_DATA_W-1:0] i_data_lines
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RESET} pfh_state_type;

	logic [`PFH_DATA_W-1:0] din_s;
	pfh_sync #(.W(`PFH_DATA_W)) u_din_sync
	(
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_async   (i_data_lines),
		.o_sync    (din_s)
	);

	pfh_state_type          state_q, state_d;
	logic [`PFH_CNT_W-1:0]  cnt_q, cnt_d;
	logic                   wr_q, wr_d;
	logic [1:0]             step_q, step_d;
	logic [1:0]             nsteps_q, nsteps_d;
	logic                   id_q, id_d;
	logic [`PFH_ADDR_W-1:0] tgt_addr_q, tgt_addr_d;
	logic [`PFH_DATA_W-1:0] tgt_data_q, tgt_data_d;
	logic                   busy_q, busy_d;
	logic                   done_q, done_d;
	logic [`PFH_DATA_W-1:0] rdata_q, rdata_d;
	logic                   perr_q, perr_d;
	logic                   rdone_q, rdone_d;
	logic                   cs_q, cs_d, og_q, og_d, we_q, we_d, rst_q, rst_d;
	logic [`PFH_ADDR_W-1:0] addr_q, addr_d;
	logic [`PFH_DATA_W-1:0] dout_q, dout_d;
	logic                   oe_q, oe_d;

	// Address and data of step n of the current sequence
	function automatic logic [`PFH_ADDR_W+`PFH_DATA_W-1:0] step_ad(input logic [1:0] n,
		input logic [`PFH_ADDR_W-1:0] a, input logic [`PFH_DATA_W-1:0] d);
		unique case (n)
			2'h0:    step_ad = {`PFH_UNLOCK_A1, `PFH_UNLOCK_D1};
			2'h1:    step_ad = {`PFH_UNLOCK_A2, `PFH_UNLOCK_D2};
			default: step_ad = {a, d};
		endcase
	endfunction

	always_comb
	begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		wr_d       = wr_q;
		step_d     = step_q;
		nsteps_d   = nsteps_q;
		id_d       = id_q;
		tgt_addr_d = tgt_addr_q;
		tgt_data_d = tgt_data_q;
		busy_d     = busy_q;
		done_d     = 1'b0;
		rdata_d    = rdata_q;
		perr_d     = perr_q;
		rdone_d    = 1'b0;
		cs_d       = cs_q;
		og_d       = og_q;
		we_d       = we_q;
		rst_d      = rst_q;
		addr_d     = addr_q;
		dout_d     = dout_q;
		oe_d       = oe_q;
		unique case (state_q)
			ST_IDLE:
			begin
				// Refuse writes while the supply is low
				if (i_req && !(i_supply_low && i_op != PFH_OP_READ))
				begin
					busy_d = 1'b1;
					cnt_d  = '0;
					step_d = 2'h0;
					perr_d = 1'b0;
					unique case (i_op)
						PFH_OP_RESET:
						begin
							rst_d   = 1'b0;
							state_d = ST_RESET;
						end
						PFH_OP_READ:
						begin
							wr_d     = 1'b0;
							nsteps_d = 2'h2;
							// Identifier reads decode only the lowest address bit, page bit low
							tgt_addr_d = id_q ? (i_addr[0] ? `PFH_ID_PART_ADDR : `PFH_ID_MAKER_ADDR) : i_addr;
							addr_d   = id_q ? (i_addr[0] ? `PFH_ID_PART_ADDR : `PFH_ID_MAKER_ADDR) : i_addr;
							cs_d     = 1'b0;
							state_d  = ST_SETUP;
						end
						PFH_OP_ID:
						begin
							// Two-step unlock plus identifier command
							wr_d       = 1'b1;
							nsteps_d   = 2'h2;
							tgt_addr_d = `PFH_UNLOCK_A1;
							tgt_data_d = `PFH_CMD_ID;
							state_d    = ST_SETUP;
						end
						default:
						begin
							// Full unlock sequence ahead of the caller's command byte
							wr_d       = 1'b1;
							nsteps_d   = 2'h2;
							tgt_addr_d = i_addr;
							tgt_data_d = i_wdata;
							state_d    = ST_SETUP;
						end
					endcase
					if (i_op == PFH_OP_WRITE || i_op == PFH_OP_ID)
					begin
						{addr_d, dout_d} = step_ad(2'h0, i_addr, i_wdata);
						oe_d = 1'b1;
						cs_d = 1'b0;
					end
				end
			end
			ST_SETUP:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= `PFH_CNT_W'(SETUP_CYC - 1))
				begin
					cnt_d = '0;
					// Write: output gate stays high, strobe falls after address is stable
					if (wr_q)
						we_d = 1'b0;
					else
						og_d = 1'b0;
					state_d = ST_STROBE;
				end
			end
			ST_STROBE:
			begin
				cnt_d = cnt_q + 1'b1;
				// Strobe width well beyond the glitch limit
				if (cnt_q >= `PFH_CNT_W'(STROBE_CYC - 1))
				begin
					cnt_d = '0;
					if (wr_q)
						we_d = 1'b1;
					else
					begin
						rdata_d = din_s;
						og_d    = 1'b1;
						perr_d  = id_q && !(^din_s);
					end
					state_d = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= `PFH_CNT_W'(HOLD_CYC - 1))
				begin
					cnt_d = '0;
					if (wr_q && step_q != nsteps_q)
					begin
						step_d = step_q + 2'h1;
						{addr_d, dout_d} = step_ad(step_q + 2'h1, tgt_addr_q, tgt_data_q);
						state_d = ST_SETUP;
					end
					else
					begin
						cs_d    = 1'b1;
						oe_d    = 1'b0;
						busy_d  = 1'b0;
						done_d  = 1'b1;
						state_d = ST_IDLE;
						// Identifier mode held across reads
						// Any other command byte, read-return or unknown, puts the flash back to array reads,
						// so the host must stop forcing identifier addresses too
						if (wr_q)
							id_d = (tgt_data_q == `PFH_CMD_ID && tgt_addr_q == `PFH_UNLOCK_A1);
					end
				end
			end
			ST_RESET:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= `PFH_CNT_W'(RESET_CYC - 1))
				begin
					rst_d   = 1'b1;
					id_d    = 1'b0;
					busy_d  = 1'b0;
					done_d  = 1'b1;
					rdone_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			state_q    <= ST_IDLE;
			cnt_q      <= '0;
			wr_q       <= 1'b0;
			step_q     <= 2'h0;
			nsteps_q   <= 2'h0;
			id_q       <= 1'b0;
			tgt_addr_q <= '0;
			tgt_data_q <= '0;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
			rdata_q    <= '0;
			perr_q     <= 1'b0;
			rdone_q    <= 1'b0;
			cs_q       <= 1'b1;
			og_q       <= 1'b1;
			we_q       <= 1'b1;
			rst_q      <= 1'b1;
			addr_q     <= '0;
			dout_q     <= '0;
			oe_q       <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			wr_q       <= wr_d;
			step_q     <= step_d;
			nsteps_q   <= nsteps_d;
			id_q       <= id_d;
			tgt_addr_q <= tgt_addr_d;
			tgt_data_q <= tgt_data_d;
			busy_q     <= busy_d;
			done_q     <= done_d;
			rdata_q    <= rdata_d;
			perr_q     <= perr_d;
			rdone_q    <= rdone_d;
			cs_q       <= cs_d;
			og_q       <= og_d;
			we_q       <= we_d;
			rst_q      <= rst_d;
			addr_q     <= addr_d;
			dout_q     <= dout_d;
			oe_q       <= oe_d;
		end
	end

	assign o_busy            = busy_q;
	assign o_done            = done_q;
	assign o_rdata           = rdata_q;
	assign o_parity_err      = perr_q;
	assign o_reset_done      = rdone_q;
	assign o_chip_select_n   = cs_q;
	assign o_output_gate_n   = og_q;
	assign o_write_strobe_n  = we_q;
	assign o_hard_init_n     = rst_q;
	// High voltage override never used; identifier entry is by command
	assign o_id_override_pin = 1'b0;
	assign o_address_lines   = addr_q;
	assign o_data_lines      = dout_q;
	assign o_data_lines_oe   = oe_q;
endmodule

/* hw/pfh_pkg.sv */
// Types for the parallel flash host controller
package pfh_pkg;
	typedef enum logic [1:0]
	{
		PFH_OP_READ,
		PFH_OP_WRITE,
		PFH_OP_ID,
		PFH_OP_RESET
	} pfh_op_type;
endpackage

/* hw/pfh_sync.sv */
// Two-flop synchroniser for a pin input
`timescale 1ns/1ps
module pfh_sync #(
	parameter int W = 8
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end
	assign o_sync = sync_q;
endmodule

/* sim/pfh_flash_model.sv */
// Behavioural byte-wide flash at its pins, resolving the shared data wire
`timescale 1ns/1ps
module pfh_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h80, // Arbitrary value, odd parity
	parameter logic [7:0] PART_CODE  = 8'h83  // Arbitrary value, odd parity
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_cs_n,
	input  wire logic        i_og_n,
	input  wire logic        i_we_n,
	input  wire logic        i_init_n,
	input  wire logic [17:0] i_addr,
	input  wire logic [7:0]  i_hdat,
	input  wire logic        i_oe,
	output logic [7:0]       o_bus
);
	logic [17:0] adr_q;
	logic [7:0]  last_q = 8'h00;
	logic [7:0]  rd;
	logic [1:0]  step = 2'h0;
	logic        id_q = 1'b0;
	logic        arm = 1'b0;
	logic        sel;
	// Undriven wire toggles each cycle so a stale byte can never pass
	// Unknown power-up values would otherwise freeze the idle pattern at X
	always @(posedge i_sys_clk)
		if (!$isunknown(o_bus))
			last_q <= o_bus;
	always @(posedge i_sys_clk)
		arm <= arm | (i_we_n & i_cs_n);
	always @(negedge i_we_n or negedge i_cs_n)
		if (!i_we_n && !i_cs_n && i_og_n)
			adr_q = i_addr;
	always @(posedge i_we_n or posedge i_cs_n or negedge i_init_n)
		if (!i_init_n)
			{step, id_q} = 3'h0;
		else if (arm && (i_we_n ^ i_cs_n) && i_og_n)
			if (step == 2'h0 && adr_q == 18'h05555 && o_bus == 8'hAA)
				step = 2'h1;
			else if (step == 2'h1 && adr_q == 18'h02AAA && o_bus == 8'h55)
				step = 2'h2;
			else
				{step, id_q} = {2'h0, step == 2'h2 && adr_q == 18'h05555 && o_bus == 8'h90};
	// Array is a fixed pattern: no command path ever alters it
	assign rd = id_q ? (i_addr[1] ? 8'hFF : i_addr[0] ? PART_CODE : MAKER_CODE)
		: i_addr[7:0] ^ 8'hA5;
	assign sel = !i_cs_n && !i_og_n && i_init_n;
	assign o_bus = i_oe ? i_hdat : sel ? rd : ~last_q;
endmodule

/* sim/pfh_host_props.sv */
// Checker on the pins of the parallel flash host controller
`timescale 1ns/1ps
module pfh_host_props
	import pfh_pkg::*;
#(
	parameter int RESET_CYC = 20
) (
	// Clock and request
	input wire logic        i_sys_clk,
	input wire logic        i_rst,
	input wire logic        i_req,
	input wire pfh_op_type  i_op,
	input wire logic        i_supply_low,
	// Answer and flash pins
	input wire logic        o_busy,
	input wire logic        o_chip_select_n,
	input wire logic        o_output_gate_n,
	input wire logic        o_write_strobe_n,
	input wire logic        o_hard_init_n,
	input wire logic [17:0] o_address_lines,
	input wire logic [7:0]  o_data_lines,
	input wire logic        o_data_lines_oe
);
	logic [7:0] lo_d;
	logic [7:0] lo_q;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	always_comb
		lo_d = o_hard_init_n ? 8'h00 : lo_q + 8'h01;
	always_ff @(posedge i_sys_clk)
		lo_q <= i_rst ? 8'h00 : lo_d;
	a_read_drive: assert property (!o_output_gate_n |-> !o_data_lines_oe && !o_chip_select_n)
		else $error("gate low while driving or deselected");
	a_write_combo: assert property ($fell(o_write_strobe_n) |-> !o_chip_select_n && o_output_gate_n)
		else $error("bad write strobe mix");
	a_addr_held: assert property (!o_write_strobe_n |-> $stable(o_address_lines))
		else $error("address moved in write");
	a_data_held: assert property ($rose(o_write_strobe_n) |-> o_data_lines_oe && $stable(o_data_lines))
		else $error("data moved at strobe end");
	a_no_glitch: assert property ($fell(o_write_strobe_n) |=> !o_write_strobe_n)
		else $error("short write strobe");
	a_init_width: assert property ($rose(o_hard_init_n) |-> lo_q == RESET_CYC)
		else $error("init pulse width");
	a_init_quiet: assert property (!o_hard_init_n |-> o_chip_select_n && o_write_strobe_n)
		else $error("bus active during init");
	a_rst_strobes: assert property ($fell(i_rst) |-> o_write_strobe_n && o_chip_select_n)
		else $error("strobe low after reset");
	a_lock_low: assert property (i_supply_low && i_req && !o_busy && i_op != PFH_OP_READ |=> !o_busy)
		else $error("write taken at low supply");
	cover property ($fell(o_write_strobe_n));
	cover property ($rose(o_hard_init_n));
	cover property (i_supply_low && i_req);
endmodule
bind pfh_host pfh_host_props #(.RESET_CYC(RESET_CYC)) u_props (.*);

/* sim/test_parallel_flash_bus_front_end.sv */
// Self-checking bench for the parallel flash host controller
`timescale 1ns/1ps
module test_parallel_flash_bus_front_end
	import pfh_pkg::*;
;
	localparam logic [7:0] MK = 8'h80; // Arbitrary value, odd parity
	localparam logic [7:0] PT = 8'h83; // Arbitrary value, odd parity
	logic        i_sys_clk = 1'b0, i_rst = 1'b1, i_req = 1'b0, i_supply_low = 1'b0;
	pfh_op_type  i_op = PFH_OP_READ;
	logic [17:0] i_addr = 18'h00000, o_address_lines;
	logic [7:0]  i_wdata = 8'h00, o_rdata, o_data_lines, i_data_lines;
	logic        o_busy, o_done, o_parity_err, o_reset_done, o_data_lines_oe, o_id_override_pin;
	logic        o_chip_select_n, o_output_gate_n, o_write_strobe_n, o_hard_init_n;
	int          n_mismatch = 0, cmp_count = 0, lat;
	always #12.5 i_sys_clk = ~i_sys_clk;
	pfh_host DUT
	(
		.i_sys_clk         (i_sys_clk),
		.i_rst             (i_rst),
		.i_req             (i_req),
		.i_op              (i_op),
		.i_addr            (i_addr),
		.i_wdata           (i_wdata),
		.i_supply_low      (i_supply_low),
		.o_busy            (o_busy),
		.o_done            (o_done),
		.o_rdata           (o_rdata),
		.o_parity_err      (o_parity_err),
		.o_reset_done      (o_reset_done),
		.o_chip_select_n   (o_chip_select_n),
		.o_output_gate_n   (o_output_gate_n),
		.o_write_strobe_n  (o_write_strobe_n),
		.o_hard_init_n     (o_hard_init_n),
		.o_id_override_pin (o_id_override_pin),
		.o_address_lines   (o_address_lines),
		.o_data_lines      (o_data_lines),
		.o_data_lines_oe   (o_data_lines_oe),
		.i_data_lines      (i_data_lines)
	);
	pfh_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT)) MDL (.i_sys_clk, .i_cs_n(o_chip_select_n),
		.i_og_n(o_output_gate_n), .i_we_n(o_write_strobe_n), .i_init_n(o_hard_init_n),
		.i_addr(o_address_lines), .i_hdat(o_data_lines), .i_oe(o_data_lines_oe), .o_bus(i_data_lines));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Counts edges from take to the done pulse; gives up at 60
	task automatic op(input pfh_op_type o, input logic [17:0] a, input logic [7:0] d);
		i_op <= o;
		i_addr <= a;
		i_wdata <= d;
		i_req <= 1'b1;
		@(posedge i_sys_clk);
		i_req <= 1'b0;
		lat = 0;
		do @(posedge i_sys_clk); while (o_done !== 1'b1 && ++lat < 60);
	endtask
	task automatic end_sim;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic t_read_lock;
		op(PFH_OP_READ, 18'h2344C, 8'h00);
		chk(8'(lat), 8'h08);
		chk(o_rdata, 8'hE9);
		chk({7'h00, o_id_override_pin}, 8'h00);
		i_supply_low <= 1'b1;
		op(PFH_OP_WRITE, 18'h05555, 8'h90);
		chk(8'(lat), 8'h3C);
		op(PFH_OP_READ, 18'h00000, 8'h00);
		chk(o_rdata, 8'hA5);
		i_supply_low <= 1'b0;
	endtask
	task automatic t_ident;
		op(PFH_OP_ID, 18'h00000, 8'h00);
		op(PFH_OP_READ, 18'h00000, 8'h00);
		chk(o_rdata, MK);
		chk({7'h00, o_parity_err}, 8'h00);
		op(PFH_OP_READ, 18'h00003, 8'h00);
		chk(o_rdata, PT);
		op(PFH_OP_WRITE, 18'h00000, 8'hF0);
		op(PFH_OP_READ, 18'h00077, 8'h00);
		chk(o_rdata, 8'hD2);
	endtask
	task automatic t_cmd;
		op(PFH_OP_WRITE, 18'h05555, 8'h90);
		op(PFH_OP_READ, 18'h00100, 8'h00);
		chk(o_rdata, MK);
		op(PFH_OP_WRITE, 18'h05555, 8'h3C);
		op(PFH_OP_READ, 18'h00133, 8'h00);
		chk(o_rdata, 8'h96);
	endtask
	// Host reset mid-run leaves the flash in identifier mode for the pin reset to clear
	task automatic t_reset;
		op(PFH_OP_ID, 18'h00000, 8'h00);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		@(posedge i_sys_clk);
		op(PFH_OP_RESET, 18'h00000, 8'h00);
		chk(8'(lat), 8'h14);
		chk({7'h00, o_reset_done}, 8'h01);
		op(PFH_OP_READ, 18'h00055, 8'h00);
		chk(o_rdata, 8'hF0);
	endtask
	initial
	begin
		repeat (16) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		@(posedge i_sys_clk);
		t_read_lock();
		t_ident();
		t_cmd();
		t_reset();
		end_sim();
	end
	// About 310 cycles are needed; six times that and more is ample
	initial
	begin
		#50000;
		n_mismatch++;
		end_sim();
	end
endmodule
